// file: hdl/asbt_pkg.sv
// Constants, register map and state encoding of the automatic serial buffer transfer block.
package asbt_pkg;

   // ------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ------------------------------------------------------------
   localparam logic [15:0] IDX_INTERVAL = 16'hFF6B; // Transfer interval control.
   localparam logic [15:0] IDX_SHIFT = 16'hFF60; // Serial shift register.
   localparam logic [15:0] IDX_MODE = 16'hFF61; // Serial mode register.
   localparam logic [15:0] IDX_CTRL = 16'hFF62; // Auto transfer control.
   localparam logic [15:0] IDX_POINTER = 16'hFF63; // Buffer address pointer.
   localparam logic [15:0] IDX_IRQ = 16'hFF64; // Serial interrupt request flag.
   localparam logic [15:0] IDX_BUF_BASE = 16'hFAC0; // First buffer RAM byte.
   localparam logic [15:0] IDX_BUF_LAST = 16'hFADF; // Last buffer RAM byte.

   // ------------------------------------------------------------
   // Field positions and reset values
   // ------------------------------------------------------------
   localparam int MODE_SER_EN = 7; // Serial enable bit.
   localparam int MODE_AUTO_EN = 6; // Automatic mode enable.
   localparam int MODE_FXX_DIV2 = 0; // Timer clock is the system clock halved.
   localparam int CTRL_RELOAD = 0; // Auto reload select.
   localparam int CTRL_RX_ON = 1; // Receive enable.
   localparam int CTRL_ACTIVE = 3; // Transfer active flag, read only.
   localparam int CTRL_BUSY_OPT = 4; // Busy input option.
   localparam int CTRL_STROBE_OPT = 5; // Strobe output option.
   localparam int INT_EN = 7; // Interval control enable.
   localparam int IRQ_FLAG = 0; // Serial interrupt request flag.
   localparam logic [7:0] INT_WMASK = 8'h9F; // Bits 5 and 6 always read zero.
   localparam logic [7:0] RESET_BYTE = 8'h00; // Reset value of every register.

   // ------------------------------------------------------------
   // Interval timing, in timer clock periods
   // ------------------------------------------------------------
   localparam int GAP_UNIT_SHIFT = 6; // Each interval step is 2^6 periods.
   localparam int GAP_MIN_OFFSET = 28; // Least fixed part of the gap.
   localparam int GAP_MAX_OFFSET = 36; // Largest fixed part of the gap.
   localparam int GAP_PIPE = 3; // Cycles spent in store, load and start.
   localparam int GAP_OFFSET = (GAP_MIN_OFFSET + GAP_MAX_OFFSET) / 2 - GAP_PIPE;
   localparam int MIN_GAP_SCK = 2; // Least gap in serial clock periods.
   localparam int GAP_W = 14; // Width of the gap counter.

   // Transfer engine states, Gray coded from load through shift and store to gap.
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_LOAD = 3'h1,
      ST_SHIFT = 3'h3,
      ST_STORE = 3'h2,
      ST_GAP = 3'h6
   } xfer_state_e;

endpackage

// file: hdl/serial_byte_shifter.sv
// Eight-bit three-wire shifter, MSB first, clock idles high.
`timescale 1ns/1ps
`default_nettype none
module serial_byte_shifter #(
   parameter int SCK_HALF = 10
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic sys_rst,
   // Byte side.
   input wire logic start,
   input wire logic [7:0] tx_byte,
   output logic [7:0] rx_byte,
   output logic done,
   // Line side.
   input wire logic serial_in,
   output logic sck,
   output logic sdo
);
   // ------------------------------------------------------------
   // Bit engine
   // ------------------------------------------------------------
   logic [15:0] half_cnt_reg; // Cycles elapsed in the current half period.
   logic [3:0] edge_cnt_reg; // Rising edges seen in this byte.
   logic run_reg; // A byte is on the wire.
   logic [7:0] sh_reg; // Shift register, transmit out of bit 7.
   wire half_end = (half_cnt_reg == 16'(SCK_HALF - 1));

   // Falling edge drives the next bit, rising edge samples the input.
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         run_reg <= 1'b0;
         sck <= 1'b1;
         sdo <= 1'b0;
         done <= 1'b0;
         sh_reg <= 8'h00;
         rx_byte <= 8'h00;
         half_cnt_reg <= 16'h0000;
         edge_cnt_reg <= 4'h0;
      end else begin
         done <= 1'b0;
         if (start && !run_reg) begin
            run_reg <= 1'b1;
            sh_reg <= tx_byte;
            sdo <= tx_byte[7];
            half_cnt_reg <= 16'h0000;
            edge_cnt_reg <= 4'h0;
         end else if (run_reg) begin
            half_cnt_reg <= half_end ? 16'h0000 : half_cnt_reg + 16'h0001;
            if (half_end && sck) begin
               sck <= 1'b0;
               sdo <= sh_reg[7];
            end else if (half_end) begin
               sck <= 1'b1;
               sh_reg <= {sh_reg[6:0], serial_in};
               edge_cnt_reg <= edge_cnt_reg + 4'h1;
               if (edge_cnt_reg == 4'h7) begin
                  run_reg <= 1'b0;
                  done <= 1'b1;
                  rx_byte <= {sh_reg[6:0], serial_in};
               end
            end
         end
      end
   end
endmodule
`default_nettype wire

// file: hdl/auto_serial_buffer_transfer.sv
// Automatic serial buffer transfer engine with a classic Wishbone register slave.
`timescale 1ns/1ps
`default_nettype none
module auto_serial_buffer_transfer #(
   parameter int SCK_HALF = 10,
   parameter int BUF_DEPTH = 32
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic sys_rst,
   // Wishbone slave.
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [17:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Serial link.
   input wire logic serial_in,
   input wire logic busy_in,
   output logic serial_clk_out,
   output logic serial_out_pin,
   output logic strobe_out_pin,
   output logic strobe_oe
);
   localparam int PTR_W = $clog2(BUF_DEPTH);

   // ------------------------------------------------------------
   // Registers and state
   // ------------------------------------------------------------
   logic [7:0] buf_mem [BUF_DEPTH]; // Shared buffer RAM.
   logic [7:0] interval_reg; // Transfer interval control.
   logic [7:0] mode_reg; // Serial mode register.
   logic [7:0] ctrl_reg; // Writable auto transfer control bits.
   logic [PTR_W-1:0] ptr_reg; // Buffer address pointer.
   logic [PTR_W-1:0] ptr_start_reg; // Pointer value at the trigger, for reload.
   logic [7:0] shift_view_reg; // Last byte seen by the shift register.
   logic active_reg; // Transfer active flag.
   logic irq_reg; // Serial interrupt request flag.
   logic auto_run_reg; // The current transfer uses the buffer.
   logic start_reg; // One-cycle start to the shifter.
   logic [7:0] tx_byte_reg; // Byte handed to the shifter.
   localparam int GAP_W_L = asbt_pkg::GAP_W;
   logic [GAP_W_L-1:0] gap_cnt_reg; // Cycles spent in the gap.
   asbt_pkg::xfer_state_e state_reg, state_next;
   wire [7:0] rx_byte;
   wire byte_done;
   wire shift_sdo;

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   wire [15:0] idx = wb_adr_i[17:2];
   wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire bus_wr = bus_req && wb_we_i && wb_sel_i[0];
   wire ram_hit = (idx >= asbt_pkg::IDX_BUF_BASE) && (idx <= asbt_pkg::IDX_BUF_LAST);
   wire [15:0] ram_off = idx - asbt_pkg::IDX_BUF_BASE;
   wire [PTR_W-1:0] cpu_ram_idx = ram_off[PTR_W-1:0];
   // The CPU owns the buffer in any cycle it addresses it while no ack is out.
   wire cpu_ram_busy = bus_req && ram_hit;
   wire ram_ok = !cpu_ram_busy;
   wire wr_shift = bus_wr && (idx == asbt_pkg::IDX_SHIFT);
   wire wr_mode = bus_wr && (idx == asbt_pkg::IDX_MODE);
   wire wr_ctrl = bus_wr && (idx == asbt_pkg::IDX_CTRL);
   wire wr_ptr = bus_wr && (idx == asbt_pkg::IDX_POINTER);
   wire wr_int = bus_wr && (idx == asbt_pkg::IDX_INTERVAL);
   wire wr_irq = bus_wr && (idx == asbt_pkg::IDX_IRQ);
   // A shift write while enabled and not active starts a sequence; its data is sent only when automatic mode is off.
   wire trigger = wr_shift && mode_reg[asbt_pkg::MODE_SER_EN] && !active_reg;
   wire auto_sel = mode_reg[asbt_pkg::MODE_AUTO_EN];
   wire rx_on = ctrl_reg[asbt_pkg::CTRL_RX_ON];
   wire reload = ctrl_reg[asbt_pkg::CTRL_RELOAD];
   wire int_en = interval_reg[asbt_pkg::INT_EN];
   wire busy_opt = ctrl_reg[asbt_pkg::CTRL_BUSY_OPT];
   wire [7:0] ctrl_view = ctrl_reg | (8'(active_reg) << asbt_pkg::CTRL_ACTIVE);

   // Read data selection; unmapped words read as zero.
   wire [7:0] rd_byte =
      ram_hit ? buf_mem[cpu_ram_idx] :
      (idx == asbt_pkg::IDX_INTERVAL) ? interval_reg :
      (idx == asbt_pkg::IDX_SHIFT) ? shift_view_reg :
      (idx == asbt_pkg::IDX_MODE) ? mode_reg :
      (idx == asbt_pkg::IDX_CTRL) ? ctrl_view :
      (idx == asbt_pkg::IDX_POINTER) ? 8'(ptr_reg) :
      (idx == asbt_pkg::IDX_IRQ) ? 8'(irq_reg) : 8'h00;

   // ------------------------------------------------------------
   // Gap timing
   // ------------------------------------------------------------
   // Steps of 2^6 timer periods, doubled when the timer runs at half rate.
   wire [GAP_W_L-1:0] n_plus1 = GAP_W_L'(interval_reg[4:0]) + GAP_W_L'(1);
   wire [GAP_W_L-1:0] gap_fxx = (n_plus1 << asbt_pkg::GAP_UNIT_SHIFT)
      + GAP_W_L'(asbt_pkg::GAP_OFFSET);
   wire [GAP_W_L-1:0] gap_sys = mode_reg[asbt_pkg::MODE_FXX_DIV2] ?
      (gap_fxx << 1) : gap_fxx;
   wire [GAP_W_L-1:0] gap_floor = GAP_W_L'(asbt_pkg::MIN_GAP_SCK * 2 * SCK_HALF);
   wire [GAP_W_L-1:0] gap_target = (gap_sys < gap_floor) ? gap_floor : gap_sys;
   // Longest timed part that the interval rule allows, used only by the checks.
   wire [GAP_W_L-1:0] gap_rule_fxx = (n_plus1 << asbt_pkg::GAP_UNIT_SHIFT)
      + GAP_W_L'(asbt_pkg::GAP_MAX_OFFSET);
   wire [GAP_W_L-1:0] gap_rule_max = mode_reg[asbt_pkg::MODE_FXX_DIV2] ?
      (gap_rule_fxx << 1) : gap_rule_fxx;
   wire gap_over = int_en ? (gap_cnt_reg >= gap_target - GAP_W_L'(1)) : !busy_in;
   wire last_byte = !auto_run_reg || (ptr_reg == '0);
   wire need_gap = int_en || busy_opt;

   // ------------------------------------------------------------
   // Transfer sequencer
   // ------------------------------------------------------------
   // Next state: load, shift, store, optional gap, back to load.
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         asbt_pkg::ST_IDLE: begin
            if (trigger) begin
               state_next = asbt_pkg::ST_LOAD;
            end
         end
         asbt_pkg::ST_LOAD: begin
            if (ram_ok) begin
               state_next = asbt_pkg::ST_SHIFT;
            end
         end
         asbt_pkg::ST_SHIFT: begin
            if (byte_done) begin
               state_next = asbt_pkg::ST_STORE;
            end
         end
         asbt_pkg::ST_STORE: begin
            if (!ram_ok) begin
               state_next = asbt_pkg::ST_STORE;
            end else if (last_byte && !(reload && auto_run_reg)) begin
               state_next = asbt_pkg::ST_IDLE;
            end else begin
               state_next = need_gap ? asbt_pkg::ST_GAP : asbt_pkg::ST_LOAD;
            end
         end
         asbt_pkg::ST_GAP: begin
            if (gap_over) begin
               state_next = asbt_pkg::ST_LOAD;
            end
         end
         default: begin
            state_next = asbt_pkg::ST_IDLE;
         end
      endcase
   end

   // State, gap counter and shifter start.
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state_reg <= asbt_pkg::ST_IDLE;
         gap_cnt_reg <= '0;
         start_reg <= 1'b0;
         tx_byte_reg <= 8'h00;
      end else begin
         state_reg <= state_next;
         gap_cnt_reg <= (state_reg == asbt_pkg::ST_GAP) ? gap_cnt_reg + GAP_W_L'(1) : '0;
         start_reg <= (state_reg == asbt_pkg::ST_LOAD) && ram_ok;
         if ((state_reg == asbt_pkg::ST_LOAD) && ram_ok) begin
            // In automatic mode the byte at base plus pointer goes to the shifter.
            tx_byte_reg <= auto_run_reg ? buf_mem[ptr_reg] : shift_view_reg;
         end
      end
   end

   // Control flags: active, interrupt and the automatic-run latch.
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         active_reg <= 1'b0;
         irq_reg <= 1'b0;
         auto_run_reg <= 1'b0;
      end else begin
         if (trigger) begin
            active_reg <= 1'b1;
            auto_run_reg <= auto_sel;
         end else if (state_reg == asbt_pkg::ST_STORE && ram_ok && last_byte
                      && !(reload && auto_run_reg)) begin
            active_reg <= 1'b0;
         end
         // A new request wins over a software clear in the same cycle.
         if (state_reg == asbt_pkg::ST_STORE && ram_ok && last_byte && !reload) begin
            irq_reg <= 1'b1;
         end else if (wr_irq && wb_dat_i[asbt_pkg::IRQ_FLAG]) begin
            irq_reg <= 1'b0;
         end
      end
   end

   // Pointer: software load while idle, hardware decrement after each automatic store, back to the start value after the store at zero.
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         ptr_reg <= '0;
         ptr_start_reg <= '0;
      end else if (trigger) begin
         ptr_start_reg <= ptr_reg;
      end else if (state_reg == asbt_pkg::ST_STORE && ram_ok && auto_run_reg) begin
         // Store first, then decrement, then the next load.
         ptr_reg <= (ptr_reg == '0) ? ptr_start_reg : ptr_reg - PTR_W'(1);
      end else if (wr_ptr && !active_reg) begin
         ptr_reg <= wb_dat_i[PTR_W-1:0];
      end
   end

   // Buffer RAM: CPU writes, or the received byte over the byte just sent.
   always_ff @(posedge clock) begin
      if (cpu_ram_busy && wb_we_i && wb_sel_i[0]) begin
         if (ram_hit) begin
            buf_mem[cpu_ram_idx] <= wb_dat_i[7:0];
         end
      end else if (state_reg == asbt_pkg::ST_STORE && auto_run_reg && rx_on) begin
         buf_mem[ptr_reg] <= rx_byte;
      end
   end

   // Software registers and the shift register view.
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         interval_reg <= asbt_pkg::RESET_BYTE;
         mode_reg <= asbt_pkg::RESET_BYTE;
         ctrl_reg <= asbt_pkg::RESET_BYTE;
         shift_view_reg <= asbt_pkg::RESET_BYTE;
      end else begin
         if (wr_int) begin
            interval_reg <= wb_dat_i[7:0] & asbt_pkg::INT_WMASK;
         end
         if (wr_mode) begin
            mode_reg <= wb_dat_i[7:0];
         end
         if (wr_ctrl) begin
            ctrl_reg <= wb_dat_i[7:0] & ~(8'h01 << asbt_pkg::CTRL_ACTIVE);
         end
         if (state_reg == asbt_pkg::ST_STORE) begin
            shift_view_reg <= rx_byte;
         end else if (wr_shift && !active_reg) begin
            shift_view_reg <= wb_dat_i[7:0];
         end
      end
   end

   // Bus answer one cycle after the request, and the line outputs.
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
         serial_out_pin <= 1'b0;
         strobe_out_pin <= 1'b0;
         strobe_oe <= 1'b0;
      end else begin
         wb_ack_o <= bus_req;
         wb_dat_o <= {24'h00_0000, rd_byte};
         serial_out_pin <= active_reg ? shift_sdo : 1'b0;
         strobe_oe <= ctrl_reg[asbt_pkg::CTRL_STROBE_OPT];
         strobe_out_pin <= ctrl_reg[asbt_pkg::CTRL_STROBE_OPT] && byte_done;
      end
   end

   // ------------------------------------------------------------
   // Shifter
   // ------------------------------------------------------------
   serial_byte_shifter #(
      .SCK_HALF(SCK_HALF)
   ) u_shifter (
      .clock(clock),
      .sys_rst(sys_rst),
      .start(start_reg),
      .tx_byte(tx_byte_reg),
      .rx_byte(rx_byte),
      .done(byte_done),
      .serial_in(serial_in),
      .sck(serial_clk_out),
      .sdo(shift_sdo)
   );

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   property p_out_low;
      @(posedge clock) disable iff (sys_rst) !active_reg |=> !serial_out_pin;
   endproperty
   a_out_low: assert property (p_out_low) else $error("data out not low while idle");

   property p_start;
      @(posedge clock) disable iff (sys_rst) trigger |=> active_reg && state_reg == asbt_pkg::ST_LOAD;
   endproperty
   a_start: assert property (p_start) else $error("trigger did not start");

   property p_end;
      @(posedge clock) disable iff (sys_rst)
         (state_reg == asbt_pkg::ST_STORE && ram_ok && last_byte && !reload)
         |=> !active_reg && irq_reg && state_reg == asbt_pkg::ST_IDLE;
   endproperty
   a_end: assert property (p_end) else $error("end of sequence not flagged");

   property p_dec;
      @(posedge clock) disable iff (sys_rst)
         (state_reg == asbt_pkg::ST_STORE && ram_ok && auto_run_reg && ptr_reg != '0)
         |=> ptr_reg == $past(ptr_reg) - PTR_W'(1);
   endproperty
   a_dec: assert property (p_dec) else $error("pointer not decremented");

   property p_store;
      @(posedge clock) disable iff (sys_rst)
         (state_reg == asbt_pkg::ST_STORE && ram_ok && auto_run_reg && rx_on)
         |=> buf_mem[$past(ptr_reg)] == $past(rx_byte);
   endproperty
   a_store: assert property (p_store) else $error("received byte not stored");

   property p_load;
      @(posedge clock) disable iff (sys_rst)
         (state_reg == asbt_pkg::ST_LOAD && ram_ok && auto_run_reg)
         |=> start_reg && tx_byte_reg == $past(buf_mem[ptr_reg]);
   endproperty
   a_load: assert property (p_load) else $error("wrong byte loaded");

   property p_no_gap;
      @(posedge clock) disable iff (sys_rst)
         (state_reg == asbt_pkg::ST_STORE && ram_ok && !last_byte && !int_en && !busy_opt)
         |=> state_reg == asbt_pkg::ST_LOAD;
   endproperty
   a_no_gap: assert property (p_no_gap) else $error("gap without interval");

   property p_gap_len;
      @(posedge clock) disable iff (sys_rst)
         (state_reg == asbt_pkg::ST_GAP && int_en)
         |-> (gap_cnt_reg < gap_rule_max || gap_cnt_reg < gap_floor)
             ##1 ($past(gap_over) || state_reg == asbt_pkg::ST_GAP);
   endproperty
   a_gap_len: assert property (p_gap_len) else $error("interval gap length wrong");

   property p_busy_ignored;
      @(posedge clock) disable iff (sys_rst)
         (state_reg == asbt_pkg::ST_GAP && int_en && gap_cnt_reg == gap_target - GAP_W_L'(1))
         |=> state_reg == asbt_pkg::ST_LOAD;
   endproperty
   a_busy_ignored: assert property (p_busy_ignored) else $error("busy stalled timed gap");

endmodule
`default_nettype wire

// file: bench/serial_peer.sv
// Serial peer model: answers each byte with its own pattern and logs what it hears.
`timescale 1ns/1ps
`default_nettype none
module serial_peer (
   // Bench reset, masks the serial clock's first rise out of unknown.
   input wire logic rst,
   // Link lines.
   input wire logic sck,
   input wire logic sdo,
   output logic sdi
);
   logic [7:0] rx_log [0:15]; // Bytes heard, in order.
   logic [7:0] tx_sh; // Byte being answered.
   logic [7:0] rx_sh; // Byte being heard.
   int n_got = 0; // Bytes heard so far.
   int nb = 0; // Bits heard of this byte.
   initial begin
      sdi = 1'b0;
      tx_sh = 8'h5A;
   end
   // The next bit goes out on the falling edge, MSB first.
   always @(negedge sck) begin
      sdi <= tx_sh[7];
      tx_sh <= {tx_sh[6:0], 1'b0};
   end
   // Sample on the rising edge; after a byte the line turns over once hold is past.
   always @(posedge sck) begin
      if (rst) begin
         nb = 0;
      end else begin
         rx_sh = {rx_sh[6:0], sdo};
         nb = nb + 1;
         if (nb == 8) begin
            rx_log[n_got] <= rx_sh;
            n_got <= n_got + 1;
            nb = 0;
            tx_sh <= 8'h5A + 8'(n_got + 1);
            sdi <= ~sdi;
         end
      end
   end
endmodule
`default_nettype wire

// file: bench/tb_top.sv
// Self-checking bench for the automatic serial buffer transfer block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam int HALF = 2; // Short serial half period keeps the run brief.
   logic clock, sys_rst, wb_cyc, wb_stb, wb_we, busy_in;
   logic [17:0] wb_adr;
   logic [3:0] wb_sel;
   logic [31:0] wb_dat, wb_dat_o;
   logic wb_ack_o, sdi, sck, sdo, strobe_out_pin, strobe_oe;
   logic sck_q; // Serial clock one cycle ago.
   logic [7:0] rd; // Last read data.
   int run_c = 0; // Cycles since the last serial clock rise.
   int gap_max = 0; // Longest rise-to-fall span seen.
   int n_mismatch = 0;
   int check_count = 0;
   auto_serial_buffer_transfer #(.SCK_HALF(HALF), .BUF_DEPTH(32)) dut_u (
      .clock(clock), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .serial_in(sdi), .busy_in(busy_in),
      .serial_clk_out(sck), .serial_out_pin(sdo), .strobe_out_pin(strobe_out_pin),
      .strobe_oe(strobe_oe));
   serial_peer peer_u (.rst(sys_rst), .sck(sck), .sdo(sdo), .sdi(sdi));
   // The clock runs at 200 MHz.
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   // Track the longest span from a serial clock rise to the next fall.
   always @(posedge clock) begin
      sck_q <= sck;
      run_c <= (sck && !sck_q) ? 0 : run_c + 1;
      if (!sck && sck_q && run_c + 1 > gap_max) begin
         gap_max <= run_c + 1;
      end
   end
   // Compare one value and count it.
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One classic Wishbone cycle; held until ack is sampled high.
   task automatic wb(input logic [15:0] idx, input logic we, input logic [7:0] wd);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_sel <= 4'h1;
      wb_adr <= {idx, 2'b00};
      wb_dat <= {24'h000000, wd};
      @(posedge clock);
      while (wb_ack_o !== 1'b1) begin
         @(posedge clock);
      end
      rd = wb_dat_o[7:0];
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      @(posedge clock);
   endtask
   // Program and trigger a sequence, then poll the active flag until it clears.
   task automatic run(input logic [7:0] ptr, mode, ctrl, intv);
      wb(asbt_pkg::IDX_POINTER, 1'b1, ptr);
      wb(asbt_pkg::IDX_MODE, 1'b1, mode);
      wb(asbt_pkg::IDX_CTRL, 1'b1, ctrl);
      wb(asbt_pkg::IDX_INTERVAL, 1'b1, intv);
      wb(asbt_pkg::IDX_SHIFT, 1'b1, 8'hEE);
      repeat (8) @(posedge clock);
      gap_max = 0;
      rd = 8'h08;
      while (rd[3] !== 1'b0) begin
         wb(asbt_pkg::IDX_CTRL, 1'b0, 8'h00);
      end
   endtask
   // Print the counts and the verdict, then stop.
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Watchdog: the whole sequence needs well under 20000 cycles.
   initial begin
      #100000;
      n_mismatch++;
      end_of_test();
   end
   // Main sequence.
   initial begin
      sys_rst = 1'b1;
      wb_cyc = 1'b0;
      wb_stb = 1'b0;
      wb_we = 1'b0;
      wb_adr = 18'h00000;
      wb_sel = 4'h0;
      wb_dat = 32'h00000000;
      busy_in = 1'b1;
      repeat (10) @(posedge clock);
      sys_rst <= 1'b0;
      @(posedge clock);
      wb(asbt_pkg::IDX_INTERVAL, 1'b0, 8'h00);
      chk("interval_reset", rd, asbt_pkg::RESET_BYTE);
      wb(asbt_pkg::IDX_INTERVAL, 1'b1, 8'hFF);
      wb(asbt_pkg::IDX_INTERVAL, 1'b0, 8'h00);
      chk("interval_mask", rd, 8'h9F);
      wb(16'h0100, 1'b0, 8'h00);
      chk("unmapped", rd, 8'h00);
      chk("strobe_oe", strobe_oe, 1'b0);
      chk("strobe_idle", strobe_out_pin, 1'b0);
      chk("sdo_idle", sdo, 1'b0);
      for (int i = 0; i < 3; i++) begin
         wb(asbt_pkg::IDX_BUF_BASE + 16'(i), 1'b1, 8'h11 * 8'(i + 1));
      end
      // Three bytes, no timed gap, receive on.
      run(8'h02, 8'hC0, 8'h02, 8'h00);
      chk("gap_off", gap_max < 40, 1'b1);
      chk("count", peer_u.n_got, 3);
      for (int i = 0; i < 3; i++) begin
         chk("sent", peer_u.rx_log[i], 8'h11 * 8'(3 - i));
         wb(asbt_pkg::IDX_BUF_BASE + 16'(i), 1'b0, 8'h00);
         chk("stored", rd, 8'h5C - 8'(i));
      end
      wb(asbt_pkg::IDX_IRQ, 1'b0, 8'h00);
      chk("irq_set", rd[0], 1'b1);
      wb(asbt_pkg::IDX_IRQ, 1'b1, 8'h01);
      wb(asbt_pkg::IDX_IRQ, 1'b0, 8'h00);
      chk("irq_clr", rd[0], 1'b0);
      chk("sdo_end", sdo, 1'b0);
      // Timed gaps with busy held high: full and halved timer clock.
      for (int d = 1; d <= 2; d++) begin
         run(8'h01, 8'hC0 | 8'(d - 1), 8'h12, 8'h80 | 8'(d - 1));
         chk("gap_lo", gap_max >= (d * 64 + 28) * d + HALF, 1'b1);
         chk("gap_hi", gap_max <= (d * 64 + 36) * d + 3 * HALF, 1'b1);
      end
      end_of_test();
   end
endmodule
`default_nettype wire
